// ==== pkg/iodi_map.svh ====
// Constants of the diagnostics and interrupt block: selectors, byte layout, fields, timing.
`ifndef IODI_MAP_SVH
`define IODI_MAP_SVH
`define IODI_SEL_DIAG_REC   16'h0001
`define IODI_SEL_DIAG_SHORT 16'h0000
`define IODI_SEL_DIAG_OBJ   16'h2F01
`define IODI_SEL_SHORT_OBJ  16'h2F00
`define IODI_SEL_DIAG_FB    16'h5005
`define IODI_SEL_PROC_FB    16'h5000
`define IODI_B_SUMMARY      5'h00
`define IODI_B_MODULE_INFO  5'h01
`define IODI_B_SPARE        5'h02
`define IODI_B_INTERNAL     5'h03
`define IODI_B_CHAN_KIND    5'h04
`define IODI_B_DIAG_BITS    5'h05
`define IODI_B_CHAN_COUNT   5'h06
`define IODI_B_GROUP_ERR    5'h07
`define IODI_B_CHAN0_ERR    5'h08
`define IODI_B_SPARE_ERR    5'h0C
`define IODI_B_TIME0        5'h10
`define IODI_REC_LEN        5'h14
`define IODI_SHORT_LEN      5'h04
`define IODI_PROC_LEN       5'h04
`define IODI_SUM_MODFAIL    0
`define IODI_SUM_INTERNAL   1
`define IODI_SUM_EXTERNAL   2
`define IODI_SUM_CHANNEL    3
`define IODI_SUM_AUX        4
`define IODI_SUM_PARAM      7
`define IODI_INT_BUFOVF     3
`define IODI_INT_COMM       4
`define IODI_INT_LOST       6
`define IODI_CH_CFG         0
`define IODI_CH_LOST        5
`define IODI_CH_UNDER       6
`define IODI_CH_OVER        7
`define IODI_RST_ZERO       8'h00
`define IODI_RST_MODULE_INFO 8'h15
`define IODI_RST_CHAN_KIND  8'h71
`define IODI_RST_DIAG_BITS  8'h08
`define IODI_RST_CHAN_COUNT 8'h04
`define IODI_US_NS          1000
`define IODI_CLK_PERIOD_NS  5
`define IODI_US_CYCLES      (`IODI_US_NS / `IODI_CLK_PERIOD_NS)
`endif

// ==== pkg/iodi_pkg.sv ====
// Types of the diagnostics and interrupt block.
package iodi_pkg;
   typedef enum logic [1:0] {
      IODI_IDLE   = 2'b00,
      IODI_ACTIVE = 2'b01
   } iodi_diag_state_type;
endpackage : iodi_pkg

// ==== logic/iodi_us_ticker.sv ====
// Free-running microsecond ticker with its clock divider.
`timescale 1ns/1ps
`include "iodi_map.svh"
module iodi_us_ticker (
   input  wire logic        clock,
   input  wire logic        reset_n,
   output logic [31:0]      us_count,
   output logic             us_tick
);
   import iodi_pkg::*;
   localparam logic [7:0] DIV_LAST = 8'(`IODI_US_CYCLES - 1);
   logic [7:0] div_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 8'h00;
      end else if (div_q == DIV_LAST) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   assign us_tick = (div_q == DIV_LAST);

   // Wraps to zero naturally after the all-ones count.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         us_count <= 32'h0000_0000;
      end else if (us_tick) begin
         us_count <= us_count + 32'h0000_0001;
      end
   end

   chk_ticker_step: assert property (@(posedge clock) disable iff (!reset_n)
      us_tick |=> us_count == $past(us_count) + 32'h0000_0001)
      else $error("Microsecond ticker did not advance by one.");
endmodule : iodi_us_ticker

// ==== logic/iodi_diag_irq.sv ====
// Diagnostics and interrupt logic of a four-channel analog input module.
`timescale 1ns/1ps
`include "iodi_map.svh"
module iodi_diag_irq (
   input  wire logic                         clock,
   input  wire logic                         reset_n,
   input  wire logic                         diag_irq_enable,
   input  wire logic [3:0]                   limit_enable,
   input  wire logic [3:0]                   over_limit,
   input  wire logic [3:0]                   under_limit,
   input  wire logic                         proc_irq_ack,
   input  wire logic [3:0]                   cfg_error,
   input  wire logic [3:0]                   range_over,
   input  wire logic [3:0]                   range_under,
   input  wire logic                         supply_fail,
   input  wire logic                         buffer_overflow,
   input  wire logic                         comm_error,
   input  wire logic                         rd_req,
   input  wire logic [15:0]                  rd_select,
   input  wire logic [4:0]                   rd_byte,
   output logic                              proc_irq,
   output logic [7:0]                        limit_over_flags,
   output logic [7:0]                        limit_under_flags,
   output logic [15:0]                       irq_time_low,
   output logic                              diag_incoming,
   output logic                              diag_going,
   output logic                              fault_indicator,
   output iodi_pkg::iodi_diag_state_type     diag_state,
   output logic                              rd_valid,
   output logic [7:0]                        rd_data,
   output logic                              rd_error
);
   import iodi_pkg::*;

   // ************************************************************
   // Ticker
   // ************************************************************
   logic [31:0] us_count;

   iodi_us_ticker u_ticker (
      .clock    (clock),
      .reset_n  (reset_n),
      .us_count (us_count),
      .us_tick  ()
   );

   // ************************************************************
   // Process interrupts
   // ************************************************************
   logic [3:0] over_prev_q;
   logic [3:0] under_prev_q;
   logic [3:0] over_evt;
   logic [3:0] under_evt;
   logic [3:0] pend_over;
   logic [3:0] pend_under;
   logic [3:0] lost_q;
   logic [3:0] lost_d;
   logic       any_evt;

   // Edges rather than levels, so a value sitting beyond its limit
   // raises one interrupt instead of one every cycle.
   assign over_evt  = over_limit & ~over_prev_q & limit_enable;
   assign under_evt = under_limit & ~under_prev_q & limit_enable;
   assign any_evt   = |{over_evt, under_evt};
   assign pend_over  = limit_over_flags[3:0];
   assign pend_under = limit_under_flags[3:0];

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         over_prev_q  <= 4'h0;
         under_prev_q <= 4'h0;
      end else begin
         over_prev_q  <= over_limit;
         under_prev_q <= under_limit;
      end
   end

   // A new event wins over an acknowledge in the same cycle.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         limit_over_flags  <= `IODI_RST_ZERO;
         limit_under_flags <= `IODI_RST_ZERO;
      end else begin
         limit_over_flags[7:4]  <= 4'h0;
         limit_under_flags[7:4] <= 4'h0;
         if (proc_irq_ack) begin
            limit_over_flags[3:0]  <= over_evt;
            limit_under_flags[3:0] <= under_evt;
         end else begin
            limit_over_flags[3:0]  <= pend_over | over_evt;
            limit_under_flags[3:0] <= pend_under | under_evt;
         end
      end
   end

   // The stamp belongs to the event that opened the interrupt.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_time_low <= 16'h0000;
      end else if (any_evt && (!proc_irq || proc_irq_ack)) begin
         irq_time_low <= us_count[15:0];
      end
   end

   assign proc_irq = |{pend_over, pend_under};

   // An event on a channel whose flag is still unacknowledged is lost.
   always_comb begin
      lost_d = lost_q;
      if (proc_irq_ack) begin
         lost_d = 4'h0;
      end
      lost_d = lost_d | (over_evt & pend_over) | (under_evt & pend_under);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lost_q <= 4'h0;
      end else begin
         lost_q <= lost_d;
      end
   end

   // ************************************************************
   // Live fault picture
   // ************************************************************
   logic [7:0] chan_live [4];
   logic [3:0] group_live;
   logic [7:0] summary_live;
   logic [7:0] internal_live;
   logic       any_fault;

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         chan_live[c] = `IODI_RST_ZERO;
         chan_live[c][`IODI_CH_CFG]   = cfg_error[c];
         chan_live[c][`IODI_CH_LOST]  = lost_q[c];
         chan_live[c][`IODI_CH_UNDER] = range_under[c];
         chan_live[c][`IODI_CH_OVER]  = range_over[c];
         group_live[c] = |chan_live[c];
      end
   end

   always_comb begin
      internal_live = `IODI_RST_ZERO;
      internal_live[`IODI_INT_BUFOVF] = buffer_overflow;
      internal_live[`IODI_INT_COMM]   = comm_error;
      internal_live[`IODI_INT_LOST]   = |lost_q;
      any_fault = |{group_live, supply_fail, buffer_overflow, comm_error};
      summary_live = `IODI_RST_ZERO;
      summary_live[`IODI_SUM_MODFAIL]  = any_fault;
      summary_live[`IODI_SUM_INTERNAL] = |internal_live;
      summary_live[`IODI_SUM_EXTERNAL] = |{range_over, range_under,
                                           supply_fail};
      summary_live[`IODI_SUM_CHANNEL]  = |group_live;
      summary_live[`IODI_SUM_AUX]      = supply_fail;
      summary_live[`IODI_SUM_PARAM]    = |cfg_error;
   end

   // ************************************************************
   // Diagnostic window
   // ************************************************************
   iodi_diag_state_type state_q;
   iodi_diag_state_type state_d;
   logic                open_win;
   logic                close_win;

   always_comb begin
      state_d   = state_q;
      open_win  = 1'b0;
      close_win = 1'b0;
      case (state_q)
         IODI_IDLE: begin
            if (any_fault) begin
               state_d  = IODI_ACTIVE;
               open_win = 1'b1;
            end
         end
         IODI_ACTIVE: begin
            if (!any_fault) begin
               state_d   = IODI_IDLE;
               close_win = 1'b1;
            end
         end
         default: begin
            state_d = IODI_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= IODI_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // The pulses are gated by the enable; the window itself always runs,
   // so the record and indicator stay truthful with interrupts switched off.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         diag_incoming <= 1'b0;
         diag_going    <= 1'b0;
      end else begin
         diag_incoming <= open_win && diag_irq_enable;
         diag_going    <= close_win && diag_irq_enable;
      end
   end

   assign fault_indicator = (state_q == IODI_ACTIVE);
   assign diag_state      = state_q;

   // ************************************************************
   // Diagnostic record
   // ************************************************************
   logic [7:0]  summary_q;
   logic [7:0]  internal_q;
   logic [7:0]  group_q;
   logic [7:0]  chan_err_q [4];
   logic [31:0] diag_time_q;

   // Snapshot on opening only: later events in the window are dropped.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         summary_q   <= `IODI_RST_ZERO;
         internal_q  <= `IODI_RST_ZERO;
         group_q     <= `IODI_RST_ZERO;
         diag_time_q <= 32'h0000_0000;
         for (int c = 0; c < 4; c++) begin
            chan_err_q[c] <= `IODI_RST_ZERO;
         end
      end else if (open_win) begin
         summary_q   <= summary_live;
         internal_q  <= internal_live;
         group_q     <= {4'h0, group_live};
         diag_time_q <= us_count;
         for (int c = 0; c < 4; c++) begin
            chan_err_q[c] <= chan_live[c];
         end
      end else if (close_win) begin
         summary_q  <= `IODI_RST_ZERO;
         internal_q <= `IODI_RST_ZERO;
         group_q    <= `IODI_RST_ZERO;
         for (int c = 0; c < 4; c++) begin
            chan_err_q[c] <= `IODI_RST_ZERO;
         end
      end
   end

   // ************************************************************
   // Record read port
   // ************************************************************
   logic       sel_full;
   logic       sel_short;
   logic       sel_proc;
   logic [7:0] rec_byte;
   logic [7:0] proc_byte;
   logic [7:0] rd_data_d;
   logic       rd_error_d;

   assign sel_full  = (rd_select == `IODI_SEL_DIAG_REC) ||
                      (rd_select == `IODI_SEL_DIAG_OBJ) ||
                      (rd_select == `IODI_SEL_DIAG_FB);
   assign sel_short = (rd_select == `IODI_SEL_DIAG_SHORT) ||
                      (rd_select == `IODI_SEL_SHORT_OBJ);
   assign sel_proc  = (rd_select == `IODI_SEL_PROC_FB);

   always_comb begin
      rec_byte = `IODI_RST_ZERO;
      case (rd_byte)
         `IODI_B_SUMMARY:     rec_byte = summary_q;
         `IODI_B_MODULE_INFO: rec_byte = `IODI_RST_MODULE_INFO;
         `IODI_B_SPARE:       rec_byte = `IODI_RST_ZERO;
         `IODI_B_INTERNAL:    rec_byte = internal_q;
         `IODI_B_CHAN_KIND:   rec_byte = `IODI_RST_CHAN_KIND;
         `IODI_B_DIAG_BITS:   rec_byte = `IODI_RST_DIAG_BITS;
         `IODI_B_CHAN_COUNT:  rec_byte = `IODI_RST_CHAN_COUNT;
         `IODI_B_GROUP_ERR:   rec_byte = group_q;
         default: begin
            if (rd_byte >= `IODI_B_TIME0 && rd_byte < `IODI_REC_LEN) begin
               rec_byte = diag_time_q[8*(rd_byte - `IODI_B_TIME0) +: 8];
            end else if (rd_byte >= `IODI_B_CHAN0_ERR &&
                         rd_byte < `IODI_B_SPARE_ERR) begin
               rec_byte = chan_err_q[2'(rd_byte - `IODI_B_CHAN0_ERR)];
            end else begin
               rec_byte = `IODI_RST_ZERO;
            end
         end
      endcase
   end

   always_comb begin
      case (rd_byte[1:0])
         2'h0:    proc_byte = limit_over_flags;
         2'h1:    proc_byte = limit_under_flags;
         2'h2:    proc_byte = irq_time_low[7:0];
         default: proc_byte = irq_time_low[15:8];
      endcase
   end

   // Out-of-range bytes read zero and are flagged, never wrap around.
   always_comb begin
      rd_data_d  = `IODI_RST_ZERO;
      rd_error_d = 1'b1;
      if (sel_full && rd_byte < `IODI_REC_LEN) begin
         rd_data_d  = rec_byte;
         rd_error_d = 1'b0;
      end else if (sel_short && rd_byte < `IODI_SHORT_LEN) begin
         rd_data_d  = rec_byte;
         rd_error_d = 1'b0;
      end else if (sel_proc && rd_byte < `IODI_PROC_LEN) begin
         rd_data_d  = proc_byte;
         rd_error_d = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_valid <= 1'b0;
         rd_data  <= `IODI_RST_ZERO;
         rd_error <= 1'b0;
      end else begin
         rd_valid <= rd_req;
         if (rd_req) begin
            rd_data  <= rd_data_d;
            rd_error <= rd_error_d;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   chk_flags_reserved: assert property (@(posedge clock) disable iff (!reset_n)
      limit_over_flags[7:4] == 4'h0 && limit_under_flags[7:4] == 4'h0)
      else $error("Reserved limit flag bits are set.");

   chk_over_sets: assert property (@(posedge clock) disable iff (!reset_n)
      over_limit[0] && !$past(over_limit[0]) && limit_enable[0]
      |=> ##0 limit_over_flags[0] && proc_irq)
      else $error("Enabled overflow edge did not raise its flag.");

   chk_disabled_quiet: assert property (@(posedge clock) disable iff (!reset_n)
      !limit_enable[1] && !limit_under_flags[1] |=> !limit_under_flags[1])
      else $error("Disabled channel raised an underflow flag.");

   chk_time_capture: assert property (@(posedge clock) disable iff (!reset_n)
      any_evt && !proc_irq |=> irq_time_low == $past(us_count[15:0]))
      else $error("Process stamp does not match the ticker.");

   chk_incoming: assert property (@(posedge clock) disable iff (!reset_n)
      state_q == IODI_IDLE && any_fault && diag_irq_enable
      |=> diag_incoming && fault_indicator && diag_time_q == $past(us_count))
      else $error("Incoming pulse or stamp missing on a new fault.");

   chk_going_clear: assert property (@(posedge clock) disable iff (!reset_n)
      diag_going |-> summary_q == 8'h00 && group_q == 8'h00 && !fault_indicator)
      else $error("Record not cleared with the going pulse.");

   chk_frozen: assert property (@(posedge clock) disable iff (!reset_n)
      state_q == IODI_ACTIVE && any_fault |=> $stable(summary_q) && $stable(group_q))
      else $error("Record changed inside the diagnostic window.");

   chk_short_read: assert property (@(posedge clock) disable iff (!reset_n)
      rd_req && rd_select == 16'h0000 && rd_byte >= 5'h04
      |=> rd_valid && rd_error && rd_data == 8'h00)
      else $error("Short read returned more than four bytes.");

   chk_module_info: assert property (@(posedge clock) disable iff (!reset_n)
      rd_req && rd_select == 16'h2F01 && rd_byte == 5'h01 |=> rd_data == 8'h15)
      else $error("Module info byte is not 15h.");

   cov_full_window: cover property (@(posedge clock) disable iff (!reset_n)
      diag_incoming ##[1:50] diag_going);
   cov_lost_irq: cover property (@(posedge clock) disable iff (!reset_n)
      $rose(lost_q[0]));
   cov_proc_read: cover property (@(posedge clock) disable iff (!reset_n)
      proc_irq ##1 rd_req && sel_proc);
endmodule : iodi_diag_irq

// ==== tb/iodi_host_model.sv ====
// Head station model that reads record bytes over the block's read port.
`timescale 1ns/1ps
module iodi_host_model (
   input  wire logic        clock,
   output logic             rd_req,
   output logic [15:0]      rd_select,
   output logic [4:0]       rd_byte,
   input  wire logic        rd_valid,
   input  wire logic [7:0]  rd_data,
   input  wire logic        rd_error
);
   initial begin
      rd_req = 1'b0;
      rd_select = 16'hFFFF;
      rd_byte = 5'h1F;
   end
   // The selector and byte index are inverted when idle so stale values never read as valid.
   task automatic read(input logic [15:0] sel, input logic [4:0] idx,
                       output logic [7:0] data, output logic err);
      @(posedge clock);
      #1;
      rd_req = 1'b1;
      rd_select = sel;
      rd_byte = idx;
      @(posedge clock);
      #1;
      rd_req = 1'b0;
      rd_select = ~sel;
      rd_byte = ~idx;
      data = rd_valid ? rd_data : 8'hXX;
      err = rd_valid ? rd_error : 1'bx;
   endtask : read
endmodule : iodi_host_model

// ==== tb/tb.sv ====
// Self-checking testbench of the diagnostics and interrupt block.
`timescale 1ns/1ps
`include "iodi_map.svh"
module tb;
   import iodi_pkg::*;
   logic                clock = 1'b0;
   logic                reset_n = 1'b0;
   logic                diag_irq_enable = 1'b1;
   logic                proc_irq_ack = 1'b0;
   logic [3:0]          limit_enable = 4'h0, over_limit = 4'h0, under_limit = 4'h0;
   logic [3:0]          cfg_error = 4'h0, range_over = 4'h0, range_under = 4'h0;
   logic [2:0]          mod_fault = 3'h0;
   logic                rd_req, rd_valid, rd_error, proc_irq, got_err;
   logic                diag_incoming, diag_going, fault_indicator;
   logic [15:0]         rd_select, irq_time_low;
   logic [4:0]          rd_byte;
   logic [7:0]          rd_data, limit_over_flags, limit_under_flags, got;
   iodi_diag_state_type diag_state;
   int                  n_fail = 0;
   int                  n_compared = 0;
   int                  n_cyc = 0;
   int                  stamp;
   logic [7:0]          int_exp [3] = '{8'h00, 8'h08, 8'h10};
   logic [7:0]          sum_exp [3] = '{8'h15, 8'h03, 8'h03};

   always #2.5 clock = ~clock;

   // Edges since reset release; the ticker value follows from this count alone.
   always @(posedge clock) begin
      if (reset_n) n_cyc++;
   end

   iodi_diag_irq iodi_diag_irq_inst (
      .clock(clock), .reset_n(reset_n), .diag_irq_enable(diag_irq_enable),
      .limit_enable(limit_enable), .over_limit(over_limit), .under_limit(under_limit),
      .proc_irq_ack(proc_irq_ack), .cfg_error(cfg_error), .range_over(range_over),
      .range_under(range_under), .supply_fail(mod_fault[0]),
      .buffer_overflow(mod_fault[1]), .comm_error(mod_fault[2]), .rd_req(rd_req),
      .rd_select(rd_select), .rd_byte(rd_byte), .proc_irq(proc_irq),
      .limit_over_flags(limit_over_flags), .limit_under_flags(limit_under_flags),
      .irq_time_low(irq_time_low), .diag_incoming(diag_incoming), .diag_going(diag_going),
      .fault_indicator(fault_indicator), .diag_state(diag_state), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_error(rd_error));

   iodi_host_model iodi_host_model_inst (
      .clock(clock), .rd_req(rd_req), .rd_select(rd_select), .rd_byte(rd_byte),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_error(rd_error));

   // ***********************************
   // Tasks
   // ***********************************
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] seen);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp

   task automatic rd(logic [15:0] sel, logic [4:0] idx, logic [7:0] exp, logic eerr);
      iodi_host_model_inst.read(sel, idx, got, got_err);
      cmp("rd_data", {8'h00, exp}, {8'h00, got});
      cmp("rd_error", {15'h0000, eerr}, {15'h0000, got_err});
   endtask : rd

   task automatic step;
      @(posedge clock);
      #1;
   endtask : step

   task automatic wait_ind(logic v);
      for (int i = 0; i < 40 && fault_indicator !== v; i++) step();
      cmp("fault_indicator", {15'h0000, v}, {15'h0000, fault_indicator});
   endtask : wait_ind

   function automatic logic [7:0] idle_byte(int i);
      case (i)
         1: return 8'h15;
         4: return 8'h71;
         5: return 8'h08;
         6: return 8'h04;
         default: return 8'h00;
      endcase
   endfunction : idle_byte

   task automatic end_sim;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   // ***********************************
   // Tests
   // ***********************************
   initial begin
      repeat (4) @(posedge clock);
      #1 reset_n = 1'b1;
      for (int i = 0; i < 20; i++) rd(16'h0001, i[4:0], idle_byte(i), 1'b0);
      rd(16'h2F01, 5'h04, 8'h71, 1'b0);
      rd(16'h5005, 5'h01, 8'h15, 1'b0);
      rd(16'h0000, 5'h03, 8'h00, 1'b0);
      rd(16'h0000, 5'h04, 8'h00, 1'b1);
      rd(16'h2F00, 5'h04, 8'h00, 1'b1);
      rd(16'h1234, 5'h00, 8'h00, 1'b1);
      repeat (450) step();
      stamp = n_cyc / `IODI_US_CYCLES;
      limit_enable = 4'h5;
      over_limit = 4'h3;
      under_limit = 4'h4;
      step();
      cmp("over", 16'h0001, {8'h00, limit_over_flags});
      cmp("under", 16'h0004, {8'h00, limit_under_flags});
      cmp("proc_irq", 16'h0001, {15'h0000, proc_irq});
      cmp("irq_time_low", 16'(stamp), irq_time_low);
      rd(16'h5000, 5'h00, 8'h01, 1'b0);
      rd(16'h5000, 5'h01, 8'h04, 1'b0);
      rd(16'h5000, 5'h02, 8'(stamp), 1'b0);
      rd(16'h5000, 5'h03, 8'(stamp >> 8), 1'b0);
      proc_irq_ack = 1'b1;
      step();
      proc_irq_ack = 1'b0;
      over_limit = 4'h0;
      under_limit = 4'h0;
      cmp("over", 16'h0000, {8'h00, limit_over_flags});
      repeat (200) step();
      stamp = n_cyc / `IODI_US_CYCLES;
      range_over = 4'h4;
      step();
      cmp("incoming", 16'h0001, {15'h0000, diag_incoming});
      cmp("fault_indicator", 16'h0001, {15'h0000, fault_indicator});
      cmp("diag_state", 16'h0001, {14'h0000, diag_state});
      cfg_error = 4'h2;
      rd(16'h0001, 5'h0A, 8'h80, 1'b0);
      rd(16'h0001, 5'h09, 8'h00, 1'b0);
      rd(16'h0001, 5'h07, 8'h04, 1'b0);
      rd(16'h0001, 5'h00, 8'h0D, 1'b0);
      rd(16'h0001, 5'h10, 8'(stamp), 1'b0);
      rd(16'h0001, 5'h11, 8'(stamp >> 8), 1'b0);
      range_over = 4'h0;
      cfg_error = 4'h0;
      step();
      cmp("going", 16'h0001, {15'h0000, diag_going});
      cmp("fault_indicator", 16'h0000, {15'h0000, fault_indicator});
      cmp("diag_state", 16'h0000, {14'h0000, diag_state});
      rd(16'h0001, 5'h0A, 8'h00, 1'b0);
      for (int k = 0; k < 3; k++) begin
         mod_fault = 3'h1 << k;
         wait_ind(1'b1);
         rd(16'h0001, 5'h03, int_exp[k], 1'b0);
         rd(16'h0001, 5'h00, sum_exp[k], 1'b0);
         mod_fault = 3'h0;
         wait_ind(1'b0);
      end
      // With the pulses switched off the window and record must still work.
      diag_irq_enable = 1'b0;
      cfg_error = 4'h1;
      step();
      cmp("incoming", 16'h0000, {15'h0000, diag_incoming});
      cmp("fault_indicator", 16'h0001, {15'h0000, fault_indicator});
      rd(16'h0001, 5'h00, 8'h89, 1'b0);
      cfg_error = 4'h0;
      step();
      cmp("going", 16'h0000, {15'h0000, diag_going});
      cmp("fault_indicator", 16'h0000, {15'h0000, fault_indicator});
      diag_irq_enable = 1'b1;
      limit_enable = 4'h1;
      over_limit = 4'h1;
      step();
      over_limit = 4'h0;
      step();
      over_limit = 4'h1;
      wait_ind(1'b1);
      rd(16'h0001, 5'h08, 8'h20, 1'b0);
      rd(16'h0001, 5'h03, 8'h40, 1'b0);
      proc_irq_ack = 1'b1;
      step();
      proc_irq_ack = 1'b0;
      over_limit = 4'h0;
      wait_ind(1'b0);
      rd(16'h0001, 5'h08, 8'h00, 1'b0);
      end_sim();
   end

   // The whole sequence needs under a thousand cycles; this bound of 20000 cycles is far beyond it.
   initial begin
      #100000;
      n_fail++;
      end_sim();
   end
endmodule : tb
